// ### kr_consts.svh
// named constants for the resistor ladder key reader
`ifndef KR_CONSTS_SVH
`define KR_CONSTS_SVH

// ==========================================================
// batch filter
`define KR_BATCH_LEN 4'hA
`define KR_BATCH_LAST 4'h9
`define KR_AVG_SHIFT 3
`define KR_SUM_ZERO 14'h0000
`define KR_CNT_ZERO 4'h0
`define KR_MAX_INIT 10'h000
`define KR_MIN_INIT 10'h3FF

// ==========================================================
// key table
`define KR_NKEYS 8
`define KR_IDX_ZERO 4'h0
`define KR_IDX_LAST 4'h8
`define KR_THR_RST 10'h3FF
`define KR_KEY_RST 4'h0

// ==========================================================
// register offsets (byte addresses)
`define KR_ADDR_CTRL 8'h00
`define KR_ADDR_STAT 8'h04
`define KR_ADDR_MASK 8'h08
`define KR_ADDR_FIX 8'h0C
`define KR_ADDR_KEY 8'h10
`define KR_ADDR_THR_BASE 3'h1
`define KR_ADDR_THR_LO 4
`define KR_ADDR_THR_HI 2

// ==========================================================
// register fields
`define KR_CTRL_START 0
`define KR_CTRL_AUTO 1
`define KR_IRQ_FIX 0
`define KR_IRQ_KEY 1
`define KR_KEY_VALID_BIT 4
`define KR_IRQ_RST 2'h0
`define KR_RDATA_ZERO 32'h00000000

`endif

// ### kr_pkg.sv
// state types for the resistor ladder key reader
`default_nettype none
`include "kr_consts.svh"

package kr_pkg;

    // ======================================================
    // converter handshake states, one-hot
    typedef enum logic [1:0] {
        KR_CONV_IDLE = 2'b01,
        KR_CONV_WAIT = 2'b10
    } kr_conv_e;

    // ======================================================
    // key scan states, one-hot
    typedef enum logic [2:0] {
        KR_SCAN_IDLE = 3'b001,
        KR_SCAN_LOOP = 3'b010,
        KR_SCAN_DONE = 3'b100
    } kr_scan_e;

    // batch filter state
    typedef struct packed {
        logic [13:0] sum;
        logic [3:0] cnt;
        logic [9:0] max;
        logic [9:0] min;
        logic [9:0] fix;
        logic fix_pulse;
    } kr_filt_s;

    // key scan state
    typedef struct packed {
        kr_scan_e state;
        logic [3:0] idx;
        logic [3:0] prev;
        logic [3:0] key;
        logic valid;
        logic accept;
    } kr_scan_s;

    // top level state
    typedef struct packed {
        kr_conv_e conv;
        logic conv_start;
        logic auto_run;
        logic flag;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
        logic [31:0] rdata;
        logic [`KR_NKEYS-1:0][9:0] thr;
    } kr_top_s;

endpackage

`default_nettype wire

// ### kr_batch_filter.sv
// ten-sample trimmed mean filter
`timescale 1ns/1ps
`default_nettype none
`include "kr_consts.svh"

module kr_batch_filter (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [9:0] sample,
    output logic [9:0] fix,
    output logic fix_pulse
);

    kr_pkg::kr_filt_s r, n; // registered state and its next value
    logic [13:0] sum_add; // sum including the new sample
    logic [9:0] max_new; // largest of the batch so far
    logic [9:0] min_new; // smallest of the batch so far
    logic [13:0] trimmed; // sum without extremes

    // ======================================================
    // next state
    always_comb begin
        n = r;
        n.fix_pulse = 1'b0;
        sum_add = r.sum + {4'h0, sample};
        max_new = (sample > r.max) ? sample : r.max;
        min_new = (sample < r.min) ? sample : r.min;
        trimmed = sum_add - {4'h0, max_new} - {4'h0, min_new};
        if (sample_valid) begin
            n.sum = sum_add;
            n.cnt = r.cnt + 4'h1;
            n.max = max_new;
            n.min = min_new;
            if (r.cnt == `KR_BATCH_LAST) begin
                n.cnt = `KR_CNT_ZERO;
                n.fix = 10'(trimmed >> `KR_AVG_SHIFT);
                n.sum = `KR_SUM_ZERO;
                n.max = `KR_MAX_INIT;
                n.min = `KR_MIN_INIT;
                n.fix_pulse = 1'b1;
            end
        end
    end

    // ======================================================
    // registers; 14 bits hold ten full-scale samples
    // sum wide enough
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r <= '{sum: `KR_SUM_ZERO, cnt: `KR_CNT_ZERO,
                   max: `KR_MAX_INIT, min: `KR_MIN_INIT,
                   fix: `KR_MAX_INIT, fix_pulse: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign fix = r.fix;
    assign fix_pulse = r.fix_pulse;

endmodule

`default_nettype wire

// ### kr_key_scan.sv
// threshold table scan with two-scan agreement
`timescale 1ns/1ps
`default_nettype none
`include "kr_consts.svh"

module kr_key_scan (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic flag,
    input wire logic [9:0] fix,
    input wire logic [`KR_NKEYS-1:0][9:0] thr,
    output logic take,
    output logic [3:0] key,
    output logic valid,
    output logic accept
);

    kr_pkg::kr_scan_s r, n; // registered state and its next value
    logic [`KR_NKEYS-1:0] above; // value exceeds each threshold

    // ======================================================
    // one comparator per table entry
    genvar gi;
    generate
        for (gi = 0; gi < `KR_NKEYS; gi = gi + 1) begin : g_cmp
            assign above[gi] = fix > thr[gi];
        end
    endgenerate

    // proceed only on a set flag
    assign take = (r.state == kr_pkg::KR_SCAN_IDLE) && flag;

    // ======================================================
    // scan sequence
    always_comb begin
        n = r;
        n.accept = 1'b0;
        case (r.state)
            kr_pkg::KR_SCAN_IDLE: begin
                if (take) begin
                    n.idx = `KR_IDX_ZERO;
                    n.state = kr_pkg::KR_SCAN_LOOP;
                end
            end
            kr_pkg::KR_SCAN_LOOP: begin
                if (r.idx == `KR_IDX_LAST) begin
                    n.state = kr_pkg::KR_SCAN_DONE;
                end else if (above[r.idx[2:0]]) begin
                    n.idx = r.idx + 4'h1;
                end else begin
                    n.state = kr_pkg::KR_SCAN_DONE;
                end
            end
            kr_pkg::KR_SCAN_DONE: begin
                if (r.idx == r.prev) begin
                    n.key = r.idx;
                    n.valid = 1'b1;
                    n.accept = 1'b1;
                end
                n.prev = r.idx;
                n.state = kr_pkg::KR_SCAN_IDLE;
            end
            default: begin
                n.state = kr_pkg::KR_SCAN_IDLE;
            end
        endcase
    end

    // ======================================================
    // registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r <= '{state: kr_pkg::KR_SCAN_IDLE, idx: `KR_IDX_ZERO,
                   prev: `KR_KEY_RST, key: `KR_KEY_RST,
                   valid: 1'b0, accept: 1'b0};
        end else begin
            r <= n;
        end
    end

    assign key = r.key;
    assign valid = r.valid;
    assign accept = r.accept;

endmodule

`default_nettype wire

// ### kr_key_reader.sv
// resistor ladder key reader: registers, converter handshake, irq
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "kr_consts.svh"

// What this block does
// - tenth conversion clears the count
// - subtract batch largest from sum
// - subtract batch smallest from sum
// - filtered value is trimmed sum over eight
// - clear sum after producing value
// - set value flag on new value
// - start bit one begins a conversion
// - scan runs only on set flag
// - scanning consumes the value flag
// - step index while value exceeds threshold
// - stop at the first miss or after all entries; index is candidate
// - accept candidate equal to previous one
// - store candidate as previous every scan
module kr_key_reader (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [9:0] conv_result,
    output logic [3:0] key_code,
    output logic key_valid,
    output logic key_accept,
    output logic irq
);

    // ======================================================
    // declarations
    kr_pkg::kr_top_s r, n; // registered state and its next value
    logic sample_valid; // completed result for the filter
    logic [9:0] fix; // filtered ladder value
    logic fix_pulse; // new filtered value this cycle
    logic take; // scan consumes the flag
    logic wr_ctrl; // write hits the control register
    logic wr_stat; // write hits the status register
    logic wr_mask; // write hits the mask register
    logic thr_hit; // address falls in the table
    logic [2:0] thr_idx; // table entry addressed
    logic [1:0] set_bits; // events this cycle
    logic [1:0] status_nxt; // status after set and clear

    assign thr_hit = reg_addr[7:5] == `KR_ADDR_THR_BASE;
    assign thr_idx = reg_addr[`KR_ADDR_THR_LO:`KR_ADDR_THR_HI];
    assign wr_ctrl = reg_wr && (reg_addr == `KR_ADDR_CTRL);
    assign wr_stat = reg_wr && (reg_addr == `KR_ADDR_STAT);
    assign wr_mask = reg_wr && (reg_addr == `KR_ADDR_MASK);

    // ======================================================
    // completion handshake
    // result taken only on the done strobe while waiting
    // the converter is on this clock, so no synchroniser
    assign sample_valid = conv_done && (r.conv == kr_pkg::KR_CONV_WAIT);

    // ======================================================
    // submodules
    kr_batch_filter u_filter (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sample_valid(sample_valid),
        .sample(conv_result),
        .fix(fix),
        .fix_pulse(fix_pulse)
    );

    kr_key_scan u_scan (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .flag(r.flag),
        .fix(fix),
        .thr(r.thr),
        .take(take),
        .key(key_code),
        .valid(key_valid),
        .accept(key_accept)
    );

    // ======================================================
    // interrupt status: a new event beats a same-cycle clear
    assign set_bits = {key_accept, fix_pulse};
    always_comb begin
        status_nxt = r.status;
        if (wr_stat) begin
            status_nxt = r.status & ~reg_wdata[1:0];
        end
        status_nxt = status_nxt | set_bits;
    end

    // ======================================================
    // next state of registers, handshake and flag
    always_comb begin
        n = r;
        n.conv_start = 1'b0;
        n.rdata = `KR_RDATA_ZERO;
        n.status = status_nxt;
        // irq follows the status it is computed from
        n.irq = |(status_nxt & n.mask);

        // register writes, decoded as a chain
        if (wr_ctrl) begin
            n.auto_run = reg_wdata[`KR_CTRL_AUTO];
        end else if (wr_mask) begin
            n.mask = reg_wdata[1:0];
            n.irq = |(status_nxt & reg_wdata[1:0]);
        end else if (reg_wr && thr_hit) begin
            n.thr[thr_idx] = reg_wdata[9:0];
        end

        // converter handshake
        case (r.conv)
            kr_pkg::KR_CONV_IDLE: begin
                if (wr_ctrl && reg_wdata[`KR_CTRL_START]) begin
                    n.conv_start = 1'b1;
                    n.conv = kr_pkg::KR_CONV_WAIT;
                end
            end
            kr_pkg::KR_CONV_WAIT: begin
                // one start per conversion, re-issued here
                if (conv_done) begin
                    if (n.auto_run) begin
                        n.conv_start = 1'b1;
                    end else begin
                        n.conv = kr_pkg::KR_CONV_IDLE;
                    end
                end
            end
            default: begin
                n.conv = kr_pkg::KR_CONV_IDLE;
            end
        endcase

        // the scan consumes the flag; a new value wins
        n.flag = (r.flag && !take) || fix_pulse;

        // register reads, data in the following cycle only
        if (reg_rd) begin
            if (reg_addr == `KR_ADDR_CTRL) begin
                n.rdata[`KR_CTRL_START] =
                    (r.conv == kr_pkg::KR_CONV_WAIT);
                n.rdata[`KR_CTRL_AUTO] = r.auto_run;
            end else if (reg_addr == `KR_ADDR_STAT) begin
                n.rdata[1:0] = r.status;
            end else if (reg_addr == `KR_ADDR_MASK) begin
                n.rdata[1:0] = r.mask;
            end else if (reg_addr == `KR_ADDR_FIX) begin
                n.rdata[9:0] = fix;
            end else if (reg_addr == `KR_ADDR_KEY) begin
                n.rdata[3:0] = key_code;
                n.rdata[`KR_KEY_VALID_BIT] = key_valid;
            end else if (thr_hit) begin
                n.rdata[9:0] = r.thr[thr_idx];
            end
        end
    end

    // ======================================================
    // state registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            r.conv <= kr_pkg::KR_CONV_IDLE;
            r.conv_start <= 1'b0;
            r.auto_run <= 1'b0;
            r.flag <= 1'b0;
            r.status <= `KR_IRQ_RST;
            r.mask <= `KR_IRQ_RST;
            r.irq <= 1'b0;
            r.rdata <= `KR_RDATA_ZERO;
            r.thr <= {`KR_NKEYS{`KR_THR_RST}};
        end else begin
            r <= n;
        end
    end

    assign reg_rdata = r.rdata;
    assign conv_start = r.conv_start;
    assign irq = r.irq;

    // ======================================================
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // helper: results seen in the current batch
    logic [3:0] seen_r;
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            seen_r <= `KR_CNT_ZERO;
        end else if (sample_valid) begin
            seen_r <= (seen_r == `KR_BATCH_LAST) ? `KR_CNT_ZERO
                                                 : seen_r + 4'h1;
        end
    end

    // start write while idle, then a single start pulse
    sequence s_start_req;
        wr_ctrl && reg_wdata[`KR_CTRL_START]
            && r.conv == kr_pkg::KR_CONV_IDLE;
    endsequence
    sequence s_one_pulse;
        conv_start ##1 !conv_start;
    endsequence
    // start write gives one start pulse
    a_start_pulse_once: assert property (
        s_start_req |=> s_one_pulse)
        else $error("start write did not pulse start once");

    // tenth result produces a filtered value
    a_batch_ten_close: assert property (
        sample_valid && seen_r == `KR_BATCH_LAST |=> fix_pulse)
        else $error("tenth result did not close batch");

    // no filtered value before the tenth result
    a_batch_no_early: assert property (
        !(sample_valid && seen_r == `KR_BATCH_LAST) |=> !fix_pulse)
        else $error("filtered value outside batch end");

    // new value raises the flag next cycle
    a_flag_raised: assert property (
        fix_pulse |=> r.flag)
        else $error("flag not raised after new value");

    // a scan that takes the flag clears it
    a_flag_consumed: assert property (
        take && !fix_pulse |=> !r.flag)
        else $error("scan did not consume the flag");

    // scan starts only from a set flag
    a_scan_needs_flag: assert property (
        u_scan.r.state == kr_pkg::KR_SCAN_IDLE && !r.flag
        |=> u_scan.r.state == kr_pkg::KR_SCAN_IDLE)
        else $error("scan ran without the flag");

    // acceptance follows a scan within bound
    sequence s_scan_taken;
        take;
    endsequence
    a_accept_bounded: assert property (
        key_accept |-> $past(take, 3) || $past(take, 4)
            || $past(take, 5) || $past(take, 6) || $past(take, 7)
            || $past(take, 8) || $past(take, 9) || $past(take, 10)
            || $past(take, 11) || $past(take, 12))
        else $error("key accepted without a scan");

    // interrupt level tracks masked status
    a_irq_level_track: assert property (
        irq == |(r.status & r.mask))
        else $error("irq does not follow masked status");

    // event in the clear cycle survives
    a_status_set_wins: assert property (
        fix_pulse && wr_stat |=> r.status[`KR_IRQ_FIX])
        else $error("status event lost to clear");

    // read data stands one cycle only
    a_rdata_idle_zero: assert property (
        !reg_rd |=> reg_rdata == `KR_RDATA_ZERO)
        else $error("read data outside the read answer");

    // ======================================================
    // checks on the filter and scan internals
    sequence s_batch_end;
        sample_valid && seen_r == `KR_BATCH_LAST;
    endsequence
    sequence s_batch_mid;
        sample_valid && seen_r != `KR_BATCH_LAST;
    endsequence

    // each result before the tenth adds into the sum
    a_sum_accumulates: assert property (
        s_batch_mid |=> u_filter.r.sum ==
            $past(u_filter.r.sum) + $past(conv_result))
        else $error("result not added to the sum");

    // batch end leaves the count at zero
    a_count_cleared: assert property (
        fix_pulse |-> u_filter.r.cnt == `KR_CNT_ZERO)
        else $error("count not cleared at batch end");

    // largest never below a result of the batch
    a_max_tracks: assert property (
        s_batch_mid |=> u_filter.r.max >= $past(conv_result))
        else $error("largest result not tracked");

    // smallest never above a result of the batch
    a_min_tracks: assert property (
        s_batch_mid |=> u_filter.r.min <= $past(conv_result))
        else $error("smallest result not tracked");

    // trimmed mean stays within the first nine extremes
    // since the second largest of ten never tops any nine
    a_fix_in_range: assert property (
        s_batch_end |=> fix <= $past(u_filter.r.max)
            && fix >= $past(u_filter.r.min))
        else $error("filtered value outside trimmed range");

    a_sum_cleared: assert property (
        s_batch_end |=> u_filter.r.sum == `KR_SUM_ZERO)
        else $error("sum not cleared after batch");

    // start pulses only after a write or a completion
    a_start_has_cause: assert property (
        conv_start |-> $past(wr_ctrl) || $past(conv_done))
        else $error("start pulse without cause");

    // a scan that takes the flag enters its loop
    a_scan_starts: assert property (
        s_scan_taken |=> u_scan.r.state == kr_pkg::KR_SCAN_LOOP)
        else $error("scan did not start on the flag");

    // step on while the value exceeds the entry
    a_idx_step: assert property (
        u_scan.r.state == kr_pkg::KR_SCAN_LOOP
            && u_scan.r.idx != `KR_IDX_LAST
            && fix > r.thr[u_scan.r.idx[2:0]]
        |=> u_scan.r.idx == $past(u_scan.r.idx) + 4'h1)
        else $error("scan did not step past entry");

    // stop at the last entry or the first miss
    a_scan_stops: assert property (
        u_scan.r.state == kr_pkg::KR_SCAN_LOOP
            && (u_scan.r.idx == `KR_IDX_LAST
            || !(fix > r.thr[u_scan.r.idx[2:0]]))
        |=> u_scan.r.state == kr_pkg::KR_SCAN_DONE)
        else $error("scan did not stop");

    // accept exactly when the candidate repeats
    a_accept_agree: assert property (
        u_scan.r.state == kr_pkg::KR_SCAN_DONE
        |=> key_accept == ($past(u_scan.r.idx) == $past(u_scan.r.prev)))
        else $error("accept does not match agreement");

    // every scan leaves its candidate as previous
    a_prev_stored: assert property (
        u_scan.r.state == kr_pkg::KR_SCAN_DONE
        |=> u_scan.r.prev == $past(u_scan.r.idx))
        else $error("candidate not stored as previous");

endmodule

`default_nettype wire

// ### kr_conv_model.sv
// behavioural converter that answers start requests of the key reader
`timescale 1ns/1ps
`default_nettype none

module kr_conv_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic conv_start,
    input wire logic [9:0] next_sample,
    input wire logic [3:0] lat,
    output logic conv_done,
    output logic [9:0] conv_result
);
    // ==========================================================
    // conversion state
    logic busy; // a conversion is running
    logic [3:0] cnt; // cycles left before completion
    logic [9:0] last; // last result handed out

    // one conversion per start; a start while busy is not queued
    // start begins single ten-bit conversion
    always @(posedge core_clk) begin
        conv_done <= 1'b0;
        // released result bus shows junk, not the old value
        conv_result <= ~last;
        if (!rst_n) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            last <= 10'h000;
        end else if (busy) begin
            // channel zero result only at completion
            if (cnt == 4'h0) begin
                conv_done <= 1'b1;
                conv_result <= next_sample;
                last <= next_sample;
                busy <= 1'b0;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end else if (conv_start) begin
            busy <= 1'b1;
            cnt <= lat;
        end
    end
endmodule

`default_nettype wire

// ### kr_key_reader_bench.sv
// self-checking bench for the resistor ladder key reader
`timescale 1ns/1ps
`default_nettype none

`define KR_CHK(nm, ex, got) begin num_checks++; \
    if ((got) !== (ex)) begin errors++; \
    $display("FAIL %s expected %0h seen %0h", nm, ex, got); end end

module kr_key_reader_bench;
    // ==========================================================
    // signals
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic conv_start, conv_done, key_valid, key_accept, irq;
    logic [9:0] conv_result;
    logic [9:0] next_sample = 10'h000;
    logic [3:0] lat = 4'h0;
    logic [3:0] key_code;
    logic [31:0] rdv; // last read word
    int errors = 0;
    int num_checks = 0;
    int n_start = 0; // start pulses seen
    int n_acc = 0; // accept pulses seen
    int n_done = 0; // completions seen
    int thr_m[8]; // reference threshold table
    int prev_m, code_m, kval_m; // reference key state

    always #50 core_clk = ~core_clk;

    kr_key_reader dut (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_start(conv_start),
        .conv_done(conv_done), .conv_result(conv_result),
        .key_code(key_code), .key_valid(key_valid),
        .key_accept(key_accept), .irq(irq));

    kr_conv_model conv (.core_clk(core_clk), .rst_n(rst_n),
        .conv_start(conv_start), .next_sample(next_sample), .lat(lat),
        .conv_done(conv_done), .conv_result(conv_result));

    // pulse counters; pulses are one cycle so each edge counts once
    always @(posedge core_clk) begin
        if (rst_n && conv_start) n_start++;
        if (rst_n && key_accept) n_acc++;
        if (rst_n && conv_done) n_done++;
    end

    // ==========================================================
    // bus tasks
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask

    // one started conversion; dbl retries the start while busy
    task conv_one(input logic [9:0] s, input bit dbl);
        int n;
        next_sample <= s;
        lat <= dbl ? 4'hC : 4'($urandom % 8);
        wr(8'h00, 32'h00000001);
        if (dbl) begin
            wr(8'h00, 32'h00000001);
            rd(8'h00);
            `KR_CHK("ctrl busy", 32'h00000001, rdv)
        end
        n = 0;
        while (conv_done !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `KR_CHK("done wait", 1'b1, conv_done)
    endtask

    // count of leading thresholds that the value exceeds
    function int cand_of(input int v);
        int i;
        i = 0;
        while (i < 8 && v > thr_m[i]) i++;
        return i;
    endfunction

    task wrap_up;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // watchdog well beyond the one to two thousand cycles of the run
    initial begin
        #3000000;
        errors++;
        wrap_up();
    end

    // ==========================================================
    // main sequence
    initial begin
        int base, s, sum, mx, mn, fix, cand, acc0, st0, mask, acc, d0;
        void'($urandom(32'hE06D131D));
        for (int i = 0; i < 8; i++) thr_m[i] = 'h3FF;
        prev_m = 0;
        code_m = 0;
        kval_m = 0;
        base = 0;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        // reset values and an unmapped place
        for (int i = 0; i < 8; i++) begin
            rd(8'(8'h20 + 4 * i));
            `KR_CHK("thr reset", 32'h000003FF, rdv)
        end
        rd(8'h40);
        `KR_CHK("unmapped", 32'h00000000, rdv)
        for (int b = 0; b < 12; b++) begin
            // table goes ascending after the first two batches
            if (b == 2) begin
                for (int i = 0; i < 8; i++) begin
                    thr_m[i] = i * 'h70 + 'h40;
                    wr(8'(8'h20 + 4 * i), 32'(thr_m[i]));
                    rd(8'(8'h20 + 4 * i));
                    `KR_CHK("thr rw", 32'(thr_m[i]), rdv)
                end
            end
            if (b % 2 == 0) base = $urandom % 1024;
            mask = b % 4;
            wr(8'h08, 32'(mask));
            sum = 0;
            mx = 0;
            mn = 'h3FF;
            st0 = n_start;
            acc0 = n_acc;
            for (int k = 0; k < 10; k++) begin
                s = base + int'($urandom % 33) - 16;
                if (b == 5 && k == 0) s = 0;
                if (b == 5 && k == 9) s = 'h3FF;
                if (b == 7) s = base;
                s = s < 0 ? 0 : (s > 'h3FF ? 'h3FF : s);
                conv_one(10'(s), b == 3 && k == 0);
                sum += s;
                mx = s > mx ? s : mx;
                mn = s < mn ? s : mn;
            end
            repeat (24) @(posedge core_clk);
            fix = (sum - mx - mn) >> 3;
            cand = cand_of(fix);
            acc = cand == prev_m;
            if (acc) begin
                code_m = cand;
                kval_m = 1;
            end
            `KR_CHK("starts", 10, n_start - st0)
            `KR_CHK("accepts", acc, n_acc - acc0)
            prev_m = cand;
            rd(8'h0C);
            `KR_CHK("filtered", 32'(fix), rdv)
            rd(8'h10);
            `KR_CHK("key", 32'(kval_m * 16 + code_m), rdv)
            rd(8'h04);
            `KR_CHK("status", 32'(acc * 2 + 1), rdv)
            `KR_CHK("irq", 1'(|((acc * 2 + 1) & mask)), irq)
            wr(8'h04, 32'h00000003);
            rd(8'h04);
            `KR_CHK("status clr", 32'h00000000, rdv)
            `KR_CHK("irq clr", 1'b0, irq)
            `KR_CHK("key pin", 4'(code_m), key_code)
            `KR_CHK("valid pin", 1'(kval_m), key_valid)
        end
        // auto mode: each completion re-issues the start
        next_sample <= 10'h200;
        lat <= 4'h0;
        st0 = n_start;
        d0 = n_done;
        wr(8'h00, 32'h00000003);
        @(posedge core_clk);
        // back-to-back status clears race the batch events
        reg_addr <= 8'h04;
        reg_wdata <= 32'h00000003;
        reg_wr <= 1'b1;
        repeat (70) @(posedge core_clk);
        reg_wr <= 1'b0;
        wr(8'h00, 32'h00000000);
        repeat (8) @(posedge core_clk);
        rd(8'h0C);
        `KR_CHK("auto fix", 32'h00000200, rdv)
        `KR_CHK("auto starts", n_done - d0, n_start - st0)
        wrap_up();
    end
endmodule

`default_nettype wire
